// file: common/dqsc_pkg.sv
`default_nettype none
package dqsc_pkg;
   // Register bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = DATA_W / 8;
   localparam int unsigned WORD_LSB = 2;

   // Register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_QSTAT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_EVSTAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h08;

   // Field layout of the command queue status word
   localparam int unsigned CNT_W = 8;
   localparam int unsigned FREE_W = 6;
   localparam int unsigned TXC_LSB = 0;
   localparam int unsigned RXC_LSB = 8;
   localparam int unsigned TXF_LSB = 16;
   localparam int unsigned RXF_LSB = 24;
   localparam int unsigned LANE_TX = TXC_LSB / 8;
   localparam int unsigned LANE_RX = RXC_LSB / 8;

   // Counter constants
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   localparam logic [FREE_W-1:0] FREE_RST = 6'h1f;
   localparam logic [FREE_W-1:0] FREE_STEP = 6'h01;
   localparam logic [FREE_W-1:0] FREE_ZERO = 6'h00;

   // Channels and event status bits
   localparam int unsigned NUM_CH = 2;
   localparam int unsigned CH_TX = 0;
   localparam int unsigned CH_RX = 1;
   localparam int unsigned EV_W = 2;
   localparam int unsigned EV_LSB = 0;

   // Bus answers and read sizes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [2:0] SZ_BYTE = 3'h0;
   localparam logic [2:0] SZ_HALF = 3'h1;

   typedef struct packed {
      logic rx_cmd_deq;
      logic rx_cmd_enq;
      logic tx_cmd_deq;
      logic tx_cmd_enq;
      logic rx_done;
      logic tx_done;
   } dqsc_evt_t;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic [EV_W-1:0] ev_sts;
      logic [EV_W-1:0] ev_mask;
   } dqsc_slv_t;

   localparam dqsc_slv_t SLV_RST = '0;
endpackage
`default_nettype wire

// file: rtl/dqsc_done_counter.sv
`timescale 1ns/1ps
`default_nettype none
module dqsc_done_counter
   import dqsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic inc,
   input wire logic clr,
   output logic [CNT_W-1:0] count
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } dqsc_cnt_t;

   dqsc_cnt_t st_ff;
   dqsc_cnt_t nxt_st;

   // A completion in the clearing cycle lands in the fresh count; saturates
   always_comb begin
      nxt_st = st_ff;
      if (clr) begin
         nxt_st.cnt = inc ? CNT_STEP : CNT_ZERO;
      end else if (inc && st_ff.cnt != CNT_MAX) begin
         nxt_st.cnt = st_ff.cnt + CNT_STEP;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign count = st_ff.cnt;
endmodule // dqsc_done_counter
`default_nettype wire

// file: rtl/dqsc_free_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module dqsc_free_tracker
   import dqsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic enq,
   input wire logic deq,
   output logic [FREE_W-1:0] free
);
   typedef struct packed {
      logic [FREE_W-1:0] free;
   } dqsc_free_t;

   dqsc_free_t st_ff;
   dqsc_free_t nxt_st;

   // Enqueue takes an entry, dequeue frees one; bounded to 0..31
   always_comb begin
      nxt_st = st_ff;
      if (enq && !deq && st_ff.free != FREE_ZERO) begin
         nxt_st.free = st_ff.free - FREE_STEP;
      end else if (deq && !enq && st_ff.free != FREE_RST) begin
         nxt_st.free = st_ff.free + FREE_STEP;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_ff.free <= FREE_RST;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign free = st_ff.free;
endmodule // dqsc_free_tracker
`default_nettype wire

// file: rtl/dqsc_status_regs.sv
// Contract
// - Transmit completion count in bits 7:0 counts each finished transmit entry or command.
// - Reading the transmit count field clears it; next read shows only newer completions.
// - Receive completion count in bits 15:8 counts each filled receive entry or command.
// - Reading the receive count field resets it to zero, or to one if a receive completion arrives in the same cycle.
// - Byte, halfword and word reads work; a byte read leaves other fields unchanged.
// - Receive count also appears in event status; reading either clears the shared count.
// - Bits 21:16 show free transmit command queue entries, 31 after reset.
// - Bits 29:24 show free receive command queue entries, 31 after reset.
`timescale 1ns/1ps
`default_nettype none
module dqsc_status_regs
   import dqsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire dqsc_evt_t evt,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] ar_size,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
      hits = (addr[ADDR_W-1:WORD_LSB] == ofs[ADDR_W-1:WORD_LSB]);
   endfunction

   // Byte lanes covered by a read of the given size at the given address
   function automatic logic [STRB_W-1:0] rd_lanes(input logic [ADDR_W-1:0] addr, input logic [2:0] size);
      logic [STRB_W-1:0] lanes;
      lanes = '1;
      case (size)
         SZ_BYTE: begin
            lanes = '0;
            lanes[addr[WORD_LSB-1:0]] = 1'b1;
         end
         SZ_HALF: begin
            lanes = addr[WORD_LSB-1] ? 4'hc : 4'h3;
         end
         default: begin
            lanes = '1;
         end
      endcase
      rd_lanes = lanes;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Signals

   dqsc_slv_t st_ff;
   dqsc_slv_t nxt_st;
   logic [CNT_W-1:0] done_cnt [NUM_CH];
   logic [FREE_W-1:0] free_cnt [NUM_CH];
   logic [NUM_CH-1:0] done_inc;
   logic [NUM_CH-1:0] done_clr;
   logic [NUM_CH-1:0] cmd_enq;
   logic [NUM_CH-1:0] cmd_deq;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic [STRB_W-1:0] ar_lanes;
   logic ar_qstat;
   logic ar_evstat;
   logic ar_imask;
   logic [DATA_W-1:0] qstat_word;
   logic [DATA_W-1:0] evstat_word;
   logic [DATA_W-1:0] imask_word;
   logic [EV_W-1:0] ev_set;

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel counters

   assign done_inc = {evt.rx_done, evt.tx_done};
   assign cmd_enq = {evt.rx_cmd_enq, evt.tx_cmd_enq};
   assign cmd_deq = {evt.rx_cmd_deq, evt.tx_cmd_deq};

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      dqsc_done_counter u_done (
         .clk_sys(clk_sys),
         .rstn(rstn),
         .ce(ce),
         .inc(done_inc[i]),
         .clr(done_clr[i]),
         .count(done_cnt[i])
      );
      dqsc_free_tracker u_free (
         .clk_sys(clk_sys),
         .rstn(rstn),
         .ce(ce),
         .enq(cmd_enq[i]),
         .deq(cmd_deq[i]),
         .free(free_cnt[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read clears

   assign ar_hs = s_axi_arvalid & s_axi_arready;
   assign ar_lanes = rd_lanes(s_axi_araddr, ar_size);
   assign ar_qstat = hits(s_axi_araddr, OFS_QSTAT);
   assign ar_evstat = hits(s_axi_araddr, OFS_EVSTAT);
   assign ar_imask = hits(s_axi_araddr, OFS_IMASK);

   // Only the lane that holds a count clears it; both lanes clear both
   assign done_clr[CH_TX] = ar_hs & ar_qstat & ar_lanes[LANE_TX];
   assign done_clr[CH_RX] = ar_hs & (ar_qstat | ar_evstat) & ar_lanes[LANE_RX];

   ////////////////////////////////////////////////////////////////////////////
   // Read words

   always_comb begin
      qstat_word = '0;
      qstat_word[TXC_LSB +: CNT_W] = done_cnt[CH_TX];
      qstat_word[RXC_LSB +: CNT_W] = done_cnt[CH_RX];
      qstat_word[TXF_LSB +: FREE_W] = free_cnt[CH_TX];
      qstat_word[RXF_LSB +: FREE_W] = free_cnt[CH_RX];
   end

   always_comb begin
      evstat_word = '0;
      evstat_word[EV_LSB +: EV_W] = st_ff.ev_sts;
      evstat_word[RXC_LSB +: CNT_W] = done_cnt[CH_RX];
   end

   always_comb begin
      imask_word = '0;
      imask_word[EV_LSB +: EV_W] = st_ff.ev_mask;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave and event status

   assign s_axi_awready = ce & ~st_ff.aw_got & ~st_ff.bvalid;
   assign s_axi_wready = ce & ~st_ff.w_got & ~st_ff.bvalid;
   assign s_axi_arready = ce & ~st_ff.rvalid;
   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs = s_axi_wvalid & s_axi_wready;
   assign ev_set = {evt.rx_done, evt.tx_done};

   always_comb begin
      nxt_st = st_ff;
      if (aw_hs) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (w_hs) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      // Both halves of a write are held; commit and answer
      if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         if (hits(st_ff.awaddr, OFS_EVSTAT)) begin
            if (st_ff.wstrb[LANE_TX]) begin
               nxt_st.ev_sts = st_ff.ev_sts & ~st_ff.wdata[EV_LSB +: EV_W];
            end
         end else if (hits(st_ff.awaddr, OFS_IMASK)) begin
            if (st_ff.wstrb[LANE_TX]) begin
               nxt_st.ev_mask = st_ff.wdata[EV_LSB +: EV_W];
            end
         end else if (!hits(st_ff.awaddr, OFS_QSTAT)) begin
            nxt_st.bresp = RESP_SLVERR;
         end
      end
      // New events win over a same-cycle clear
      nxt_st.ev_sts = nxt_st.ev_sts | ev_set;
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      // Read data is the value before the clear
      if (ar_hs) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_OKAY;
         if (ar_qstat) begin
            nxt_st.rdata = qstat_word;
         end else if (ar_evstat) begin
            nxt_st.rdata = evstat_word;
         end else if (ar_imask) begin
            nxt_st.rdata = imask_word;
         end else begin
            nxt_st.rdata = '0;
            nxt_st.rresp = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_ff <= SLV_RST;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // Valids are gated so no handshake completes while state is frozen
   assign s_axi_bvalid = st_ff.bvalid & ce;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid & ce;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign irq = |(st_ff.ev_sts & st_ff.ev_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   tx_count_inc_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && evt.tx_done && !done_clr[CH_TX] && done_cnt[CH_TX] != CNT_MAX)
      |=> done_cnt[CH_TX] == $past(done_cnt[CH_TX]) + CNT_STEP)
      else $error("tx completion count did not advance");

   tx_read_clear_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && ar_hs && ar_qstat && ar_lanes[LANE_TX] && !evt.tx_done)
      |=> done_cnt[CH_TX] == CNT_ZERO && s_axi_rdata[TXC_LSB +: CNT_W] == $past(done_cnt[CH_TX]))
      else $error("tx count not returned and cleared by read");

   rx_count_inc_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && evt.rx_done && !done_clr[CH_RX] && done_cnt[CH_RX] != CNT_MAX)
      |=> done_cnt[CH_RX] == $past(done_cnt[CH_RX]) + CNT_STEP)
      else $error("rx completion count did not advance");

   rx_read_clear_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && ar_hs && ar_qstat && ar_lanes[LANE_RX] && !evt.rx_done)
      |=> done_cnt[CH_RX] == CNT_ZERO && s_axi_rdata[RXC_LSB +: CNT_W] == $past(done_cnt[CH_RX]))
      else $error("rx count not returned and cleared by read");

   byte_read_keep_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && ar_hs && ar_size == SZ_BYTE && !ar_lanes[LANE_RX] && !evt.rx_done)
      |=> done_cnt[CH_RX] == $past(done_cnt[CH_RX]))
      else $error("byte read disturbed the rx count");

   alias_clear_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && ar_hs && ar_evstat && ar_lanes[LANE_RX] && !evt.rx_done)
      ##1 (s_axi_rvalid || !ce)
      |-> done_cnt[CH_RX] == CNT_ZERO && s_axi_rdata[RXC_LSB +: CNT_W] == $past(done_cnt[CH_RX]))
      else $error("event status read did not clear rx count");

   tx_free_field_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && ar_hs && ar_qstat)
      |=> s_axi_rdata[TXF_LSB +: FREE_W] == $past(free_cnt[CH_TX]) && free_cnt[CH_TX] <= FREE_RST)
      else $error("tx free count field wrong");

   rx_free_field_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && ar_hs && ar_qstat)
      |=> s_axi_rdata[RXF_LSB +: FREE_W] == $past(free_cnt[CH_RX]) && free_cnt[CH_RX] <= FREE_RST)
      else $error("rx free count field wrong");

   same_cycle_keep_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && ar_hs && ar_qstat && (&ar_lanes[LANE_RX:LANE_TX]) && evt.tx_done && evt.rx_done)
      |=> done_cnt[CH_TX] == CNT_STEP && done_cnt[CH_RX] == CNT_STEP)
      else $error("completion lost during clearing read");

   // A write committing in the same cycle may change the mask, so it is left out
   irq_level_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && evt.tx_done && st_ff.ev_mask[CH_TX] && !(st_ff.aw_got && st_ff.w_got))
      |=> irq)
      else $error("masked-in event did not raise the interrupt");

   read_answer_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ar_hs |=> st_ff.rvalid)
      else $error("read address taken without a read answer");

   write_answer_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) |=> st_ff.bvalid && !st_ff.aw_got)
      else $error("complete write not answered");

   bad_read_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ar_hs && !ar_qstat && !ar_evstat && !ar_imask)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not refused");

   bad_write_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && st_ff.aw_got && st_ff.w_got && !st_ff.bvalid && !hits(st_ff.awaddr, OFS_QSTAT)
       && !hits(st_ff.awaddr, OFS_EVSTAT) && !hits(st_ff.awaddr, OFS_IMASK))
      |=> s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");

   sticky_set_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && evt.rx_done) |=> st_ff.ev_sts[CH_RX])
      else $error("rx event did not set its status bit");

   sticky_clear_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && st_ff.aw_got && st_ff.w_got && !st_ff.bvalid && hits(st_ff.awaddr, OFS_EVSTAT)
       && st_ff.wstrb[LANE_TX] && st_ff.wdata[EV_LSB + CH_TX] && !evt.tx_done)
      |=> !st_ff.ev_sts[CH_TX])
      else $error("write of one did not clear tx status bit");

   tx_free_dec_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && evt.tx_cmd_enq && !evt.tx_cmd_deq && free_cnt[CH_TX] != FREE_ZERO)
      |=> free_cnt[CH_TX] == $past(free_cnt[CH_TX]) - FREE_STEP)
      else $error("tx free count did not drop on enqueue");

   rx_free_inc_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (ce && evt.rx_cmd_deq && !evt.rx_cmd_enq && free_cnt[CH_RX] != FREE_RST)
      |=> free_cnt[CH_RX] == $past(free_cnt[CH_RX]) + FREE_STEP)
      else $error("rx free count did not rise on dequeue");

   frozen_state_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (!ce) |=> done_cnt[CH_TX] == $past(done_cnt[CH_TX]) && st_ff.ev_sts == $past(st_ff.ev_sts))
      else $error("state moved while clock enable was low");

endmodule // dqsc_status_regs
`default_nettype wire

// file: sim/dqsc_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dqsc_status_regs_tb
   import dqsc_pkg::*;
;
   localparam dqsc_evt_t EV_NONE = 6'h00;
   localparam dqsc_evt_t EV_TXD = 6'h01;
   localparam dqsc_evt_t EV_RXD = 6'h02;
   localparam dqsc_evt_t EV_BOTH = 6'h03;
   localparam logic [2:0] SZ_WORD = 3'h2;
   logic clk_sys, rstn, ce;
   dqsc_evt_t evt;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [STRB_W-1:0] s_axi_wstrb;
   logic [2:0] ar_size;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] rd_data;
   logic [1:0] resp;

   dqsc_status_regs dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .evt(evt),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .ar_size(ar_size),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Event inputs are applied on the same edge as the read address
   task automatic ax_rd(input logic [7:0] a, input logic [2:0] sz, input dqsc_evt_t ev);
      s_axi_araddr <= a;
      ar_size <= sz;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      evt <= ev;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      evt <= EV_NONE;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd_chk(input string n, input logic [7:0] a, input logic [2:0] sz, input dqsc_evt_t ev,
                         input logic [31:0] exp);
      ax_rd(a, sz, ev);
      check(n, rd_data, exp);
   endtask

   task automatic ax_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys);
         if (s_axi_awready && !aw_ok) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w_ok) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic pulse(input dqsc_evt_t ev, input int n);
      repeat (n) begin
         evt <= ev;
         @(posedge clk_sys);
      end
      evt <= EV_NONE;
      @(posedge clk_sys);
   endtask

   task automatic irq_chk(input logic exp);
      #1;
      check("irq", {31'h0, irq}, {31'h0, exp});
      @(posedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_chk("status after reset", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f0000);
      rd_chk("events after reset", OFS_EVSTAT, SZ_WORD, EV_NONE, 32'h00000000);
      irq_chk(1'b0);
   endtask

   task automatic t_counts();
      pulse(EV_TXD, 3);
      pulse(EV_RXD, 5);
      rd_chk("tx byte read", OFS_QSTAT, SZ_BYTE, EV_NONE, 32'h1f1f0503);
      rd_chk("after tx byte", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f0500);
      pulse(EV_RXD, 1);
      rd_chk("rx byte read", 8'h01, SZ_BYTE, EV_NONE, 32'h1f1f0100);
      rd_chk("after rx byte", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f0000);
   endtask

   task automatic t_alias();
      pulse(EV_RXD, 2);
      pulse(EV_TXD, 1);
      rd_chk("alias byte read", 8'h05, SZ_BYTE, EV_NONE, 32'h00000203);
      rd_chk("after alias", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f0001);
   endtask

   task automatic t_same();
      rd_chk("read with done", OFS_QSTAT, SZ_WORD, EV_BOTH, 32'h1f1f0000);
      rd_chk("kept done", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f0101);
      pulse(EV_BOTH, 1);
      rd_chk("half read", OFS_QSTAT, SZ_HALF, EV_NONE, 32'h1f1f0101);
      rd_chk("after half", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f0000);
      pulse(EV_TXD, 260);
      rd_chk("saturated", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f00ff);
   endtask

   task automatic t_free();
      pulse(6'h14, 32);
      rd_chk("queues full", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h00000000);
      pulse(6'h28, 1);
      pulse(6'h3c, 1);
      rd_chk("one free", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h01010000);
      pulse(6'h28, 30);
      rd_chk("all free", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f0000);
   endtask

   task automatic t_irq();
      irq_chk(1'b0);
      ax_wr(OFS_IMASK, 32'h1);
      irq_chk(1'b1);
      pulse(EV_TXD, 1);
      irq_chk(1'b1);
      rd_chk("tx count masked in", OFS_QSTAT, SZ_BYTE, EV_NONE, 32'h1f1f0001);
      ax_wr(OFS_EVSTAT, 32'h1);
      irq_chk(1'b0);
      rd_chk("sticky left", OFS_EVSTAT, SZ_WORD, EV_NONE, 32'h00000002);
      ax_wr(OFS_EVSTAT, 32'h2);
      ax_wr(OFS_IMASK, 32'h2);
      pulse(EV_RXD, 1);
      irq_chk(1'b1);
      ax_wr(OFS_EVSTAT, 32'h2);
      irq_chk(1'b0);
      rd_chk("count in events", OFS_EVSTAT, SZ_WORD, EV_NONE, 32'h00000100);
   endtask

   task automatic t_errors();
      ax_rd(8'h0c, SZ_WORD, EV_NONE);
      check("unmapped read data", rd_data, 32'h0);
      check("unmapped read resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      ax_wr(8'h10, 32'hffffffff);
      check("unmapped write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      ax_wr(OFS_QSTAT, 32'hffffffff);
      check("status write resp", {30'h0, resp}, {30'h0, RESP_OKAY});
      rd_chk("status not written", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f0000);
   endtask

   task automatic t_ce();
      ce <= 1'b0;
      pulse(EV_TXD, 1);
      #1;
      check("arready frozen", {31'h0, s_axi_arready}, 32'h0);
      @(posedge clk_sys);
      ce <= 1'b1;
      @(posedge clk_sys);
      rd_chk("frozen count", OFS_QSTAT, SZ_WORD, EV_NONE, 32'h1f1f0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      evt = EV_NONE;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = '0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      ar_size = SZ_WORD;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_counts();
      t_alias();
      t_same();
      t_free();
      t_irq();
      t_errors();
      t_ce();
      stop_test();
   end
endmodule // dqsc_status_regs_tb
`default_nettype wire
